// ==== verilog/adc_digital_backend.sv ====
/*
  ADC digital back-end: per-channel gain, DC offset removal with
  enable and hold, saturation with sticky overflow, pin functions,
  speed mode decode and serial output routing with one-line mode.
  Assumes decimated samples and control port strobes on i_mclk.
*/
`timescale 1ns/100ps
// Notes on behaviour
// - Sample words are two's complement.
// - Clip to largest positive or negative code.
// - Clipping sets overflow flag in status.
// - Multipurpose pins can show the overflow condition.
// - Left and right gain set separately.
// - Active filter tracks and subtracts DC offset.
// - Offset filter has its own enable.
// - Hold freezes offset, keeps subtracting it.
// - Hold bit lives in misc control.
// - Speed field picks one of three modes.
// - Single rate: up to 50 kHz, ratio 128.
// - Double rate: up to 100 kHz, ratio 64.
// - Quad rate: up to 192 kHz, ratio 32.
// - Codec output carries internal words, plus external words in one-line mode.
// - Receiver output may carry converter words instead.
// - One-line mode interleaves two external stereo inputs.
// - Frame clock marks left or right, either source.
module adc_digital_backend (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic i_dec_valid,
  input wire logic [23:0] i_dec_left,
  input wire logic [23:0] i_dec_right,
  input wire logic i_receiver_audio,
  input wire logic i_ext_converter_in_a,
  input wire logic i_ext_converter_in_b,
  input wire logic i_frame_lr_clock,
  output logic o_frame_lr_clock,
  output logic o_frame_lr_clock_oe,
  input wire logic i_serial_bit_clock,
  output logic o_serial_bit_clock,
  output logic o_serial_bit_clock_oe,
  output logic o_codec_serial_out,
  output logic o_receiver_serial_out,
  output logic [6:0] o_multipurpose_pin,
  output logic [6:0] o_multipurpose_pin_oe,
  output logic [7:0] o_oversample_ratio,
  output logic [7:0] o_max_rate_khz,
  output logic o_sample_valid,
  output logic [23:0] o_sample_left,
  output logic [23:0] o_sample_right
);

  ////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] functional_mode_cfg;
  logic [7:0] misc_control_cfg;
  logic [7:0] gain_left_cfg;
  logic [7:0] gain_right_cfg;
  logic [7:0] multipurpose_pin_cfg [0:6];
  logic [7:0] event_status;

  logic wr_func;
  logic wr_misc;
  logic pin_hit;
  logic [2:0] pin_index;
  logic status_read;

  assign wr_func = i_reg_wr && i_reg_addr == adc_backend_pkg::ADDR_FUNC_MODE;
  assign wr_misc = i_reg_wr && i_reg_addr == adc_backend_pkg::ADDR_MISC;
  assign pin_hit = i_reg_addr >= adc_backend_pkg::ADDR_PIN_FIRST &&
                   i_reg_addr <= adc_backend_pkg::ADDR_PIN_LAST;
  assign pin_index = 3'(i_reg_addr - adc_backend_pkg::ADDR_PIN_FIRST);
  assign status_read = i_reg_rd && i_reg_addr == adc_backend_pkg::ADDR_STATUS;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      functional_mode_cfg <= adc_backend_pkg::FUNC_MODE_RST;
    end else if (wr_func) begin
      functional_mode_cfg <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      misc_control_cfg <= adc_backend_pkg::MISC_RST;
    end else if (wr_misc) begin
      misc_control_cfg <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      gain_left_cfg <= adc_backend_pkg::GAIN_RST;
      gain_right_cfg <= adc_backend_pkg::GAIN_RST;
    end else if (i_reg_wr) begin
      if (i_reg_addr == adc_backend_pkg::ADDR_GAIN_LEFT) begin
        gain_left_cfg <= i_reg_wdata;
      end
      if (i_reg_addr == adc_backend_pkg::ADDR_GAIN_RIGHT) begin
        gain_right_cfg <= i_reg_wdata;
      end
    end
  end

  genvar p;
  generate
    for (p = 0; p < 7; p++) begin : g_pin
      always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
          multipurpose_pin_cfg[p] <= adc_backend_pkg::PIN_RST;
        end else if (i_reg_wr && pin_hit && pin_index == 3'(p)) begin
          multipurpose_pin_cfg[p] <= i_reg_wdata;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Gain, offset removal and saturation per channel

  logic hpf_enable;
  logic offset_hold;
  logic [1:0] clip;
  logic [23:0] clipped [0:1];
  logic [23:0] proc_word [0:1];

  assign hpf_enable = misc_control_cfg[adc_backend_pkg::HPF_EN_BIT];
  assign offset_hold = misc_control_cfg[adc_backend_pkg::HOLD_BIT];

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_chan
      logic signed [23:0] raw;
      logic signed [8:0] gain;
      logic signed [32:0] product;
      logic signed [26:0] scaled;
      logic signed [26:0] offset;
      logic signed [27:0] diff;
      logic signed [27:0] result;
      logic signed [27:0] step;

      assign raw = (c == 0) ? i_dec_left : i_dec_right;
      assign gain = (c == 0) ? {1'b0, gain_left_cfg} : {1'b0, gain_right_cfg};
      // Unsigned gain with six fraction bits: 8'h40 is unity
      assign product = raw * gain;
      assign scaled = 27'(product >>> adc_backend_pkg::GAIN_FRAC_BITS);
      assign diff = 28'(scaled) - 28'(offset);
      assign step = diff >>> adc_backend_pkg::HPF_LEAK_SHIFT;
      // Held offset is still removed after the filter is disabled
      assign result = (hpf_enable || offset_hold) ? diff : 28'(scaled);

      // Leaky integrator; slow on purpose so audio band passes
      always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
          offset <= 27'sh000_0000;
        end else if (i_dec_valid && hpf_enable && !offset_hold) begin
          offset <= 27'(28'(offset) + step);
        end
      end

      always_comb begin
        clip[c] = 1'b0;
        clipped[c] = result[23:0];
        if (result > 28'sh07F_FFFF) begin
          clipped[c] = adc_backend_pkg::SAMPLE_MAX;
          clip[c] = 1'b1;
        end else if (result < -28'sh080_0000) begin
          clipped[c] = adc_backend_pkg::SAMPLE_MIN;
          clip[c] = 1'b1;
        end
      end

      always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
          proc_word[c] <= 24'h00_0000;
        end else if (i_dec_valid) begin
          proc_word[c] <= clipped[c];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_sample_valid <= 1'b0;
      o_sample_left <= 24'h00_0000;
      o_sample_right <= 24'h00_0000;
    end else begin
      o_sample_valid <= i_dec_valid;
      if (i_dec_valid) begin
        o_sample_left <= clipped[0];
        o_sample_right <= clipped[1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Overflow status; a new clip beats the clear on read

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      event_status <= 8'h00;
    end else if (i_dec_valid && |clip) begin
      event_status[adc_backend_pkg::OVF_BIT] <= 1'b1;
    end else if (status_read) begin
      event_status <= 8'h00;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      if (i_reg_addr == adc_backend_pkg::ADDR_FUNC_MODE) begin
        o_reg_rdata <= functional_mode_cfg;
      end else if (i_reg_addr == adc_backend_pkg::ADDR_MISC) begin
        o_reg_rdata <= misc_control_cfg;
      end else if (i_reg_addr == adc_backend_pkg::ADDR_GAIN_LEFT) begin
        o_reg_rdata <= gain_left_cfg;
      end else if (i_reg_addr == adc_backend_pkg::ADDR_GAIN_RIGHT) begin
        o_reg_rdata <= gain_right_cfg;
      end else if (status_read) begin
        o_reg_rdata <= event_status;
      end else if (pin_hit) begin
        o_reg_rdata <= multipurpose_pin_cfg[pin_index];
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Multipurpose pins

  generate
    for (p = 0; p < 7; p++) begin : g_pin_out
      adc_backend_pkg::pin_func_t func;
      assign func = adc_backend_pkg::pin_func_t'(multipurpose_pin_cfg[p][1:0]);
      always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
          o_multipurpose_pin[p] <= 1'b0;
          o_multipurpose_pin_oe[p] <= 1'b0;
        end else begin
          unique case (func)
            adc_backend_pkg::pin_drive_low: begin
              o_multipurpose_pin[p] <= 1'b0;
              o_multipurpose_pin_oe[p] <= 1'b1;
            end
            adc_backend_pkg::pin_drive_high: begin
              o_multipurpose_pin[p] <= 1'b1;
              o_multipurpose_pin_oe[p] <= 1'b1;
            end
            adc_backend_pkg::pin_overflow: begin
              o_multipurpose_pin[p] <= event_status[adc_backend_pkg::OVF_BIT];
              o_multipurpose_pin_oe[p] <= 1'b1;
            end
            adc_backend_pkg::pin_receiver_in: begin
              o_multipurpose_pin[p] <= 1'b0;
              o_multipurpose_pin_oe[p] <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Speed mode

  adc_backend_pkg::speed_select_t speed_select;
  assign speed_select = adc_backend_pkg::speed_select_t'(
    functional_mode_cfg[adc_backend_pkg::SPEED_LSB +: 2]);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_oversample_ratio <= adc_backend_pkg::OSR_SINGLE;
      o_max_rate_khz <= adc_backend_pkg::MAX_KHZ_SINGLE;
    end else begin
      unique case (speed_select)
        adc_backend_pkg::double_rate_mode: begin
          o_oversample_ratio <= adc_backend_pkg::OSR_DOUBLE;
          o_max_rate_khz <= adc_backend_pkg::MAX_KHZ_DOUBLE;
        end
        adc_backend_pkg::quad_rate_mode: begin
          o_oversample_ratio <= adc_backend_pkg::OSR_QUAD;
          o_max_rate_khz <= adc_backend_pkg::MAX_KHZ_QUAD;
        end
        // Reserved code falls back to single rate
        default: begin
          o_oversample_ratio <= adc_backend_pkg::OSR_SINGLE;
          o_max_rate_khz <= adc_backend_pkg::MAX_KHZ_SINGLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Serial clocks: generated here or taken from the host

  logic clk_master;
  logic one_line;
  logic route_to_receiver;
  logic [3:0] pin_level;
  logic sclk_prev;
  logic lrck_prev;
  logic div_cnt;
  logic [6:0] bit_cnt;
  logic bit_rise;
  logic bit_fall;
  logic frame_edge;
  logic frame_level;

  assign clk_master = functional_mode_cfg[adc_backend_pkg::CLK_MASTER_BIT];
  assign one_line = functional_mode_cfg[adc_backend_pkg::ONE_LINE_BIT];
  assign route_to_receiver = functional_mode_cfg[adc_backend_pkg::RX_ROUTE_BIT];

  pin_level_sync #(
    .WIDTH(4)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async({i_ext_converter_in_b, i_ext_converter_in_a,
              i_frame_lr_clock, i_serial_bit_clock}),
    .o_level(pin_level)
  );

  // Generator: bit clock mclk/4, frame flips after 128 bit periods
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || !clk_master) begin
      div_cnt <= 1'b0;
      bit_cnt <= 7'h00;
      o_serial_bit_clock <= 1'b0;
      o_frame_lr_clock <= 1'b0;
    end else if (div_cnt == adc_backend_pkg::SCLK_DIV_LAST) begin
      div_cnt <= 1'b0;
      o_serial_bit_clock <= !o_serial_bit_clock;
      if (o_serial_bit_clock) begin
        bit_cnt <= bit_cnt + 7'h01;
        if (bit_cnt == adc_backend_pkg::HALF_LAST) begin
          o_frame_lr_clock <= !o_frame_lr_clock;
        end
      end
    end else begin
      div_cnt <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_serial_bit_clock_oe <= 1'b0;
      o_frame_lr_clock_oe <= 1'b0;
    end else begin
      o_serial_bit_clock_oe <= clk_master;
      o_frame_lr_clock_oe <= clk_master;
    end
  end

  // Edge view of whichever source is active
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sclk_prev <= 1'b0;
      lrck_prev <= 1'b0;
    end else begin
      sclk_prev <= clk_master ? o_serial_bit_clock : pin_level[0];
      lrck_prev <= frame_level;
    end
  end

  assign frame_level = clk_master ? o_frame_lr_clock : pin_level[1];
  assign bit_rise = !sclk_prev && (clk_master ? o_serial_bit_clock : pin_level[0]);
  assign bit_fall = sclk_prev && !(clk_master ? o_serial_bit_clock : pin_level[0]);
  assign frame_edge = frame_level != lrck_prev;

  ////////////////////////////////////////////////////////////////////
  // External converter lines and output serializer

  logic [23:0] ext_a_left;
  logic [23:0] ext_a_right;
  logic [23:0] ext_b_left;
  logic [23:0] ext_b_right;
  logic [71:0] out_shift;

  ext_word_capture u_ext_a (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_bit_rise(bit_rise),
    .i_frame_edge(frame_edge),
    .i_frame_level(lrck_prev),
    .i_data(pin_level[2]),
    .o_left(ext_a_left),
    .o_right(ext_a_right)
  );

  ext_word_capture u_ext_b (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_bit_rise(bit_rise),
    .i_frame_edge(frame_edge),
    .i_frame_level(lrck_prev),
    .i_data(pin_level[3]),
    .o_left(ext_b_left),
    .o_right(ext_b_right)
  );

  // Frame level high carries left words; MSB leads at the edge
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      out_shift <= 72'h0;
    end else if (frame_edge) begin
      if (one_line) begin
        out_shift <= frame_level ? {proc_word[0], ext_a_left, ext_b_left} :
                                   {proc_word[1], ext_a_right, ext_b_right};
      end else begin
        out_shift <= {frame_level ? proc_word[0] : proc_word[1], 48'h0};
      end
    end else if (bit_fall) begin
      out_shift <= {out_shift[70:0], 1'b0};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_codec_serial_out <= 1'b0;
      o_receiver_serial_out <= 1'b0;
    end else begin
      o_codec_serial_out <= out_shift[71];
      o_receiver_serial_out <= route_to_receiver ? out_shift[71] : i_receiver_audio;
    end
  end

endmodule

// ==== verilog/adc_backend_pkg.sv ====
/*
  Shared constants for the ADC digital back-end: register offsets,
  field positions, reset values, encodings and serial frame counts.
  Assumes a byte-wide control port decoded upstream of the block.
*/
package adc_backend_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_FUNC_MODE = 8'h03;
  localparam logic [7:0] ADDR_MISC = 8'h05;
  localparam logic [7:0] ADDR_GAIN_LEFT = 8'h1C;
  localparam logic [7:0] ADDR_GAIN_RIGHT = 8'h1D;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_PIN_FIRST = 8'h29;
  localparam logic [7:0] ADDR_PIN_LAST = 8'h2F;

  // Field positions
  localparam int SPEED_LSB = 6;
  localparam int ONE_LINE_BIT = 0;
  localparam int CLK_MASTER_BIT = 1;
  localparam int RX_ROUTE_BIT = 2;
  localparam int HOLD_BIT = 0;
  localparam int HPF_EN_BIT = 1;
  localparam int OVF_BIT = 0;

  // Reset values
  localparam logic [7:0] FUNC_MODE_RST = 8'h00;
  localparam logic [7:0] MISC_RST = 8'h02;
  localparam logic [7:0] GAIN_RST = 8'h40;
  localparam logic [7:0] PIN_RST = 8'h03;

  typedef enum logic [1:0] {
    single_rate_mode,
    double_rate_mode,
    quad_rate_mode,
    rate_reserved
  } speed_select_t;

  typedef enum logic [1:0] {
    pin_drive_low,
    pin_drive_high,
    pin_overflow,
    pin_receiver_in
  } pin_func_t;

  // Oversampling ratios and rate ceilings in kHz
  localparam logic [7:0] OSR_SINGLE = 8'h80;
  localparam logic [7:0] OSR_DOUBLE = 8'h40;
  localparam logic [7:0] OSR_QUAD = 8'h20;
  localparam logic [7:0] MAX_KHZ_SINGLE = 8'd50;
  localparam logic [7:0] MAX_KHZ_DOUBLE = 8'd100;
  localparam logic [7:0] MAX_KHZ_QUAD = 8'd192;

  // Datapath
  localparam int WORD_BITS = 24;
  localparam int GAIN_FRAC_BITS = 6;
  localparam int HPF_LEAK_SHIFT = 10;
  localparam logic [23:0] SAMPLE_MAX = 24'h7F_FFFF;
  localparam logic [23:0] SAMPLE_MIN = 24'h80_0000;

  // Serial frame: bit clock is mclk / 4, 128 bit slots per half frame
  localparam logic [0:0] SCLK_DIV_LAST = 1'h1;
  localparam logic [6:0] HALF_LAST = 7'h7F;
  localparam logic [4:0] WORD_LAST = 5'h17;

endpackage

// ==== verilog/pin_level_sync.sv ====
/*
  Three-stage synchroniser for a group of pin inputs.
  A change is accepted once the second and third stages agree.
  Assumes inputs are asynchronous to i_mclk.
*/
`timescale 1ns/100ps
module pin_level_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          o_level[b] <= 1'b0;
        end else begin
          s1 <= i_async[b];
          s2 <= s1;
          s3 <= s2;
          // Glitch of one stage is not taken
          if (s2 == s3) begin
            o_level[b] <= s3;
          end
        end
      end
    end
  endgenerate

endmodule

// ==== verilog/ext_word_capture.sv ====
/*
  Captures one external stereo converter line: 24-bit words, MSB
  first, left justified to the frame clock edge, sampled on bit
  clock rising edges. Assumes event pulses come from i_mclk logic.
*/
`timescale 1ns/100ps
module ext_word_capture (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_bit_rise,
  input wire logic i_frame_edge,
  input wire logic i_frame_level,
  input wire logic i_data,
  output logic [23:0] o_left,
  output logic [23:0] o_right
);

  logic [23:0] shift;
  logic [4:0] count;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      shift <= 24'h00_0000;
      count <= 5'h00;
    end else if (i_frame_edge) begin
      count <= 5'h00;
    end else if (i_bit_rise && count <= adc_backend_pkg::WORD_LAST) begin
      shift <= {shift[22:0], i_data};
      count <= count + 5'h01;
    end
  end

  // Word of the half just ended; level before the edge names it
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_left <= 24'h00_0000;
      o_right <= 24'h00_0000;
    end else if (i_frame_edge) begin
      if (i_frame_level) begin
        o_left <= shift;
      end else begin
        o_right <= shift;
      end
    end
  end

endmodule

// ==== sim/adc_backend_asserts.sv ====
/*
  Port checker for the ADC back-end: sample strobe, read data,
  speed decode and generated serial clocks.
  Assumes it is bound to adc_digital_backend, one clock domain.
*/
`timescale 1ns/100ps
module adc_backend_asserts (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_dec_valid,
  input wire logic o_frame_lr_clock,
  input wire logic o_frame_lr_clock_oe,
  input wire logic o_serial_bit_clock,
  input wire logic o_serial_bit_clock_oe,
  input wire logic [7:0] o_oversample_ratio,
  input wire logic [7:0] o_max_rate_khz,
  input wire logic o_sample_valid,
  input wire logic [23:0] o_sample_left,
  input wire logic [23:0] o_sample_right
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////
  // Bit clock: two cycles high, two low
  sequence sclk_cycle;
    o_serial_bit_clock [*2] ##1 !o_serial_bit_clock [*2] ##1 o_serial_bit_clock;
  endsequence
  a_valid_follows: assert property (i_dec_valid |=> o_sample_valid)
    else $error("sample strobe missing");
  a_valid_pulse: assert property (!i_dec_valid |=> !o_sample_valid)
    else $error("sample strobe without input");
  a_words_hold: assert property (!o_sample_valid |->
    $stable(o_sample_left) && $stable(o_sample_right)) else $error("words moved");
  a_rdata_holds: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
    else $error("read data moved");
  a_ratio_pairs: assert property ((o_oversample_ratio == 8'h80 &&
    o_max_rate_khz == 8'h32) || (o_oversample_ratio == 8'h40 && o_max_rate_khz == 8'h64)
    || (o_oversample_ratio == 8'h20 && o_max_rate_khz == 8'hC0)) else $error("bad ratio");
  a_oe_together: assert property (o_frame_lr_clock_oe == o_serial_bit_clock_oe)
    else $error("clock enables differ");
  a_slave_quiet: assert property ((!o_serial_bit_clock_oe) [*2] |->
    !o_serial_bit_clock && !o_frame_lr_clock) else $error("clock driven as slave");
  a_sclk_period: assert property ($rose(o_serial_bit_clock) |-> sclk_cycle)
    else $error("bit clock period wrong");
  a_frame_steady: assert property ($changed(o_frame_lr_clock) |=>
    $stable(o_frame_lr_clock) [*8]) else $error("frame clock glitch");
endmodule
bind adc_digital_backend adc_backend_asserts adc_backend_asserts_i (.i_mclk, .i_rst_n,
  .i_reg_rd, .o_reg_rdata, .i_dec_valid, .o_frame_lr_clock, .o_frame_lr_clock_oe,
  .o_serial_bit_clock, .o_serial_bit_clock_oe, .o_oversample_ratio, .o_max_rate_khz,
  .o_sample_valid, .o_sample_left, .o_sample_right);

// ==== sim/audio_host_model.sv ====
/*
  Serial audio host: takes the first 48 bits of every left half
  and counts the words taken, saturating at three.
  Assumes device-driven clocks, oversampled by i_mclk.
*/
`timescale 1ns/100ps
module audio_host_model (
  input wire logic i_mclk,
  input wire logic i_lr,
  input wire logic i_sclk,
  input wire logic i_data,
  output logic [47:0] o_left_word,
  output logic [1:0] o_done
);
  logic lr_q = 0, sclk_q = 0;
  logic [5:0] cnt = 6'h30;
  logic [47:0] sh = '0;
  initial o_done = 0;
  initial o_left_word = '0;
  always @(posedge i_mclk) begin
    lr_q <= i_lr;
    sclk_q <= i_sclk;
    if (i_lr && !lr_q) begin
      cnt <= 6'h00;
    end else if (i_sclk && !sclk_q && cnt < 6'h30) begin
      sh <= {sh[46:0], i_data};
      cnt <= cnt + 6'h01;
      if (cnt == 6'h2F) begin
        o_left_word <= {sh[46:0], i_data};
        if (o_done != 2'h3) begin
          o_done <= o_done + 2'h1;
        end
      end
    end
  end
endmodule

// ==== sim/adc_digital_backend_test.sv ====
/*
  Self-checking bench for the ADC back-end: registers, gain, clip,
  offset filter, speed modes, pins and serial output.
  Assumes slave clock pins and converter line b idle low.
*/
`timescale 1ns/100ps
module adc_digital_backend_test;
  logic i_mclk = 0, i_rst_n = 0, wr_s = 0, rd_s = 0, dv = 0, rx = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, osr, khz;
  logic [23:0] dl = 0, dr = 0, sl, sr, h;
  logic [47:0] hw, hr;
  logic [6:0] pin, pin_oe;
  logic lr, lr_oe, sck, sck_oe, cso, rso, sv, ea = 0;
  logic [1:0] hd;
  int miscompares = 0, samples_checked = 0;
  logic [7:0] ra [8] = '{8'h03, 8'h05, 8'h1C, 8'h1D, 8'h20, 8'h29, 8'h2F, 8'h40};
  logic [7:0] rv [8] = '{8'h00, 8'h02, 8'h40, 8'h40, 8'h00, 8'h03, 8'h03, 8'h00};
  logic [7:0] os [4] = '{8'h80, 8'h40, 8'h20, 8'h80};
  logic [7:0] kz [4] = '{8'h32, 8'h64, 8'hC0, 8'h32};
  logic [7:0] gl [4] = '{8'h40, 8'h80, 8'h80, 8'hFF};
  logic [7:0] gr [4] = '{8'h20, 8'h20, 8'hFF, 8'h40};
  logic [23:0] tl [4] = '{24'h00_1000, 24'h40_0000, 24'hC0_0000, 24'h80_0000};
  logic [23:0] tr [4] = '{24'hFF_F000, 24'h80_0000, 24'h00_0040, 24'h7F_FFFF};
  logic [23:0] el [4] = '{24'h00_1000, 24'h7F_FFFF, 24'h80_0000, 24'h80_0000};
  logic [23:0] er [4] = '{24'hFF_F800, 24'hC0_0000, 24'h00_00FF, 24'h7F_FFFF};
  logic [3:0] fl = 4'b1010;
  always #2 i_mclk = ~i_mclk;
  adc_digital_backend adc_digital_backend_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_reg_addr(addr), .i_reg_wr(wr_s), .i_reg_wdata(wdata), .i_reg_rd(rd_s),
    .o_reg_rdata(rdata), .i_dec_valid(dv), .i_dec_left(dl), .i_dec_right(dr),
    .i_receiver_audio(rx), .i_ext_converter_in_a(ea), .i_ext_converter_in_b(1'b0),
    .i_frame_lr_clock(1'b0), .o_frame_lr_clock(lr), .o_frame_lr_clock_oe(lr_oe),
    .i_serial_bit_clock(1'b0), .o_serial_bit_clock(sck), .o_serial_bit_clock_oe(sck_oe),
    .o_codec_serial_out(cso), .o_receiver_serial_out(rso), .o_multipurpose_pin(pin),
    .o_multipurpose_pin_oe(pin_oe), .o_oversample_ratio(osr), .o_max_rate_khz(khz),
    .o_sample_valid(sv), .o_sample_left(sl), .o_sample_right(sr));
  audio_host_model audio_host_model_i (.i_mclk(i_mclk), .i_lr(lr), .i_sclk(sck),
    .i_data(cso), .o_left_word(hw), .o_done(hd));
  audio_host_model audio_host_model_rx_i (.i_mclk(i_mclk), .i_lr(lr), .i_sclk(sck),
    .i_data(rso), .o_left_word(hr), .o_done());
  ////////////////////////////////
  task automatic close_out();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic step();
    @(posedge i_mclk);
    #1;
  endtask
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Each strobe drops and a clock passes, so calls can follow directly
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a; wdata = d; wr_s = 1; step(); wr_s = 0; step();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a; rd_s = 1; step(); rd_s = 0; step(); chk(rdata, exp);
  endtask
  task automatic smp(input logic [23:0] l, input logic [23:0] r);
    dl = l; dr = r; dv = 1; step(); dv = 0;
    chk(sv, 1);
    step();
  endtask
  // Bounded wait for the host's word count; running out is a mismatch
  task automatic wait_word(input logic [1:0] n);
    for (int t = 0; t < 3000 && hd !== n; t++) step();
    if (hd !== n) miscompares++;
  endtask
  initial begin
    repeat (2) @(posedge i_mclk);
    #1 i_rst_n = 1;
    wr(8'h20, 8'hFF);
    wr(8'h40, 8'hFF);
    foreach (ra[k]) rd(ra[k], rv[k]);
    chk(osr, 8'h80);
    rx = 1; step(); step();
    chk(rso, 1);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h03, 8'(m << 6));
      step();
      chk(osr, os[m]);
      chk(khz, kz[m]);
    end
    $display("test speed done");
    wr(8'h05, 8'h00);
    wr(8'h29, 8'h02);
    wr(8'h2F, 8'h01);
    rd(8'h20, 8'h00);
    chk(pin_oe, 7'b100_0001);
    chk(pin, 7'b100_0000);
    for (int k = 0; k < 4; k++) begin
      wr(8'h1C, gl[k]);
      wr(8'h1D, gr[k]);
      smp(tl[k], tr[k]);
      chk(sl, el[k]);
      chk(sr, er[k]);
      smp(24'h00_0000, 24'h00_0000);
      chk(pin[0], fl[k]);
      rd(8'h20, 8'(fl[k]));
      chk(pin[0], 0);
    end
    $display("test clip done");
    wr(8'h1C, 8'h40);
    wr(8'h1D, 8'h40);
    wr(8'h05, 8'h02);
    repeat (40) smp(24'h01_0000, 24'h01_0000);
    chk(24'(sl < 24'h01_0000), 1);
    wr(8'h05, 8'h03);
    smp(24'h01_0000, 24'h01_0000);
    h = sl;
    smp(24'h01_0000, 24'h01_0000);
    chk(sl, h);
    smp(24'h02_0000, 24'h02_0000);
    chk(sl, h + 24'h01_0000);
    wr(8'h05, 8'h01);
    smp(24'h01_0000, 24'h01_0000);
    chk(sl, h);
    wr(8'h05, 8'h00);
    smp(24'h01_0000, 24'h01_0000);
    chk(sl, 24'h01_0000);
    $display("test filter done");
    smp(24'hA5_5A3C, 24'h12_3456);
    ea = 1;
    wr(8'h03, 8'h07);
    chk(sck_oe, 1);
    chk(lr_oe, 1);
    // External words lag one frame, so the first left slot holds zeros
    wait_word(2'h1);
    chk(hw, 48'hA55A_3C00_0000);
    chk(hr, 48'hA55A_3C00_0000);
    wait_word(2'h2);
    chk(hw, 48'hA55A_3CFF_FFFF);
    $display("test serial done");
    close_out();
  end
endmodule
